// ### dv/rcs_asserts.sv
// Port checker for the selector.
// Assumes a bind onto the top module.
`timescale 1ns/10ps
`default_nettype none
module rcs_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        squelchForce,
  input wire logic        recovered_clock_out_two
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wait;
    penable && !pready;
  endsequence
  chk_ready_due: assert property (s_wait |=> pready) else $error("late");
  chk_ready_once: assert property (pready |=> !pready) else $error("long");
  chk_ready_cause: assert property (pready |-> $past(penable)) else $error("stray");
  chk_err_addr: assert property (pready |-> pslverr == (paddr != 12'h018)) else $error("err");
  chk_err_data: assert property (pslverr && !pwrite |-> !prdata) else $error("data");
  chk_rsvd_zero:
    assert property (pready && !pwrite |-> !prdata[31:16] && !prdata[7:6] && !prdata[3])
    else $error("rsvd");
  chk_force_low:
    assert property (squelchForce [*3] |-> !recovered_clock_out_two) else $error("force");
  chk_reset_quiet:
    assert property (disable iff (1'b0) !rst_n |=> !(pready | pslverr | recovered_clock_out_two))
    else $error("reset");
endmodule : rcs_asserts
bind rcs_recovered_clock_output_select rcs_asserts i_rcs_asserts (.*);
`default_nettype wire

// ### dv/rcs_line_model.sv
// Line clocks: serial port p halves every 2**p clk, copper 2**(p+1).
// Assumes one clk; recovered clocks run free, as line clocks do.
`timescale 1ns/10ps
`default_nettype none
module rcs_line_model (
  input wire logic       clk,
  output logic     [3:0] serialClk,
  output logic     [3:0] copperClk
);
  logic [4:0] cnt_ff = 5'h0;
  // Free-running line clocks need no reset; the initial value starts them
  always @(posedge clk) cnt_ff <= cnt_ff + 5'h1;
  assign {copperClk, serialClk} = {cnt_ff[4:1], cnt_ff[3:0]};
endmodule : rcs_line_model
`default_nettype wire

// ### dv/rcs_tb.sv
// Self-checking bench for the selector.
// Assumes rcs_line_model drives the line clocks.
`timescale 1ns/10ps
`default_nettype none
`include "rcs_cfg.svh"
module testbench;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, squelchForce, out, pa, en, run;
  logic [1:0]  p, s;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  serialClk, copperClk, linkUp, linkUnstable, gigMaster, tenBaseT, eeeMode, lpIdleRx;
  logic [32:0] q[$];
  int          errors, check_count, rises, exp;
  rcs_recovered_clock_output_select i_rcs_recovered_clock_output_select (.*,
    .recovered_clock_out_two(out));
  rcs_line_model i_rcs_line_model (.*);
  initial forever #12.5 clk = ~clk;
  task automatic check(input logic [32:0] got, input logic [32:0] want);
    check_count++;
    if (got !== want) begin
      errors++;
      $display("Error %0t got %h exp %h", $time, got, want);
    end
  endtask : check
  task automatic give_verdict;
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // Reply is queued first; the monitor pops it when pready shows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, x);
    q.push_back({a != `RCS_CTRL_ADDR, x});
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    repeat (16) if (pready !== 1'b1) @(posedge clk);
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      errors++;
      give_verdict();
    end
  endtask : apb
  task automatic measure(input int n);
    logic prev;
    repeat (8) @(posedge clk);
    prev = out;
    rises = 0;
    repeat (n) begin
      @(posedge clk);
      if (out === 1'b1 && prev === 1'b0) rises++;
      prev = out;
    end
  endtask : measure
  always @(posedge clk) begin
    if (pready === 1'b1) check({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
  end
  initial begin
    void'($urandom(32'h4ece_7755));
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata, squelchForce} = '0;
    {linkUp, linkUnstable, gigMaster, tenBaseT, eeeMode, lpIdleRx} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `RCS_CTRL_ADDR, 32'h0, 32'h0);
    apb(1'b1, `RCS_CTRL_ADDR, 32'hffff_ffff, 32'h0);
    apb(1'b1, 12'h01c, 32'h0, 32'h0);
    apb(1'b0, 12'h01c, 32'h0, 32'h0);
    apb(1'b0, `RCS_CTRL_ADDR, 32'h0, 32'hff37);
    measure(64);
    check(rises, 0);
    for (int f = 0; f < 3; f++) begin
      p = 2'($urandom);
      pa = f[0];
      apb(1'b1, `RCS_CTRL_ADDR, {16'h0, 1'b1, 2'b0, p, f[2:0], 7'h18, pa}, 32'h0);
      measure(1280);
      exp = 1280 / ((f == 0 ? 20 : f == 1 ? 4 : 16) << (3'(p) + pa));
      check(rises >= exp - 1 && rises <= exp + 1, 1'b1);
    end
    apb(1'b1, `RCS_CTRL_ADDR, 32'h0000_8132, 32'h0);
    measure(64);
    check(rises, 0);
    repeat (48) begin
      {en, p, s} = 5'($urandom);
      apb(1'b1, `RCS_CTRL_ADDR, {16'h0, en, 2'b0, p, 5'h4, s, 4'h0}, 32'h0);
      {linkUp, lpIdleRx} <= 8'($urandom);
      {linkUnstable, gigMaster, tenBaseT, eeeMode} <= 16'($urandom & $urandom);
      squelchForce <= $urandom % 6 == 0;
      measure(64);
      case (s)
        2'b00: run = linkUp[p] & ~|{linkUnstable[p], gigMaster[p], tenBaseT[p], eeeMode[p]};
        2'b01: run = linkUp[p] & ~linkUnstable[p] & (~eeeMode[p] | lpIdleRx[p]);
        2'b10: run = linkUp[p];
        default: run = 1'b1;
      endcase
      check(rises != 0, run & en & ~squelchForce);
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// ### hdl/rcs_cfg.svh
// Register map and field layout of the recovered clock two selector.
// Assumes inclusion by bare name from the bench or design files.
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH
`define RCS_CTRL_ADDR     12'h0018
`define RCS_CTRL_RESET    16'h0000
`define RCS_CTRL_WMASK    16'hFF37
`define RCS_ENABLE_BIT    15
`define RCS_SRC_HI        14
`define RCS_SRC_LO        11
`define RCS_FREQ_HI       10
`define RCS_FREQ_LO       8
`define RCS_SQL_HI        5
`define RCS_SQL_LO        4
`define RCS_PATH_HI       2
`define RCS_PATH_LO       0
`define RCS_NUM_PORTS     4
`define RCS_DIV125        3'h1
`define RCS_DIV25         3'h5
`define RCS_DIV31         3'h4
`endif

// ### hdl/rcs_pkg.sv
// Types of the recovered clock two selector.
// Assumes rcs_cfg.svh defines the numeric layout.
package rcs_pkg;
  typedef enum logic [1:0] {
    RCS_SQL_AUTO,
    RCS_SQL_AUTO_EXT,
    RCS_SQL_LINKDOWN,
    RCS_SQL_OFF
  } rcs_squelch_t;
  typedef enum logic [1:0] {
    RCS_FREQ_25,
    RCS_FREQ_125,
    RCS_FREQ_31,
    RCS_FREQ_RSVD
  } rcs_freq_t;
endpackage : rcs_pkg

// ### hdl/rcs_recovered_clock_output_select.sv
// Control register, source select, divider and squelch for recovered clock two.
// Assumes APB master on clk; per-port clocks arrive as synchronous 625 MHz-derived
// enables sampled on clk (modelled as 1-bit line-rate toggles per port).
//
// How it works
// - Output drives only while enable bit 15 is set; reset value zero.
// - Bits 14:11 choose port zero to three; other codes reserved, output held low.
// - Bits 10:8 set rate 25, 125 or 31.25 MHz; reserved codes hold low.
// - Squelch 00 holds low on link down, unstable, master, 10BASE-T or EEE.
// - Squelch 01 runs also in master, 10BASE-T, and EEE while LP_IDLE received.
// - Squelch 10 holds low only when the selected link is down.
// - Squelch 11 never squelches; clock runs even with link down.
// - External squelch-force input high squelches output regardless of settings.
// - Bits 2:0 pick serial media (000) or copper (001) clock; others reserved.
`timescale 1ns/10ps
`default_nettype none
`include "rcs_cfg.svh"

module rcs_recovered_clock_output_select #(
  parameter int NPORTS = `RCS_NUM_PORTS
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NPORTS-1:0] serialClk,
  input  wire logic [NPORTS-1:0] copperClk,
  input  wire logic [NPORTS-1:0] linkUp,
  input  wire logic [NPORTS-1:0] linkUnstable,
  input  wire logic [NPORTS-1:0] gigMaster,
  input  wire logic [NPORTS-1:0] tenBaseT,
  input  wire logic [NPORTS-1:0] eeeMode,
  input  wire logic [NPORTS-1:0] lpIdleRx,
  input  wire logic              squelchForce,
  output logic                   recovered_clock_out_two
);

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic        hit;

  // One wait state: setup, access, ready in the access cycle after
  always_comb begin
    hit         = (paddr == `RCS_CTRL_ADDR);
    nxt_ctrl    = ctrl_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    if (psel && penable && !pready_ff) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = !hit;
      if (pwrite && hit) begin
        nxt_ctrl = pwdata[15:0] & `RCS_CTRL_WMASK;
      end
      nxt_prdata = hit ? {16'h0000, ctrl_ff} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff    <= `RCS_CTRL_RESET;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ------------------------------------------------------------
  // Source select and squelch decision
  // ------------------------------------------------------------
  logic [3:0]          srcSel;
  logic [2:0]          freqSel;
  logic [2:0]          pathSel;
  rcs_pkg::rcs_squelch_t sqlMode;
  logic                portOk;
  logic                pathOk;
  logic                freqOk;
  logic                srcClk;
  logic                squelch;
  logic [NPORTS-1:0]   portClk;
  logic [1:0]          port;

  assign srcSel  = ctrl_ff[`RCS_SRC_HI:`RCS_SRC_LO];
  assign freqSel = ctrl_ff[`RCS_FREQ_HI:`RCS_FREQ_LO];
  assign pathSel = ctrl_ff[`RCS_PATH_HI:`RCS_PATH_LO];
  assign sqlMode = rcs_pkg::rcs_squelch_t'(ctrl_ff[`RCS_SQL_HI:`RCS_SQL_LO]);
  assign portOk  = (srcSel < 4'(NPORTS));
  assign pathOk  = (pathSel[2:1] == 2'b00);
  assign freqOk  = (freqSel < 3'h3);
  assign port    = srcSel[1:0];

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : gPortClk
      assign portClk[g] = pathSel[0] ? copperClk[g] : serialClk[g];
    end
  endgenerate

  assign srcClk = portClk[port];

  always_comb begin
    squelch = 1'b1;
    case (sqlMode)
      rcs_pkg::RCS_SQL_AUTO: begin
        squelch = !linkUp[port] || linkUnstable[port] || gigMaster[port]
                  || tenBaseT[port] || eeeMode[port];
      end
      rcs_pkg::RCS_SQL_AUTO_EXT: begin
        squelch = !linkUp[port] || linkUnstable[port]
                  || (eeeMode[port] && !lpIdleRx[port]);
      end
      rcs_pkg::RCS_SQL_LINKDOWN: begin
        squelch = !linkUp[port];
      end
      rcs_pkg::RCS_SQL_OFF: begin
        squelch = 1'b0;
      end
      default: begin
        squelch = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Divider and output
  // ------------------------------------------------------------
  // Divides rising edges of the selected line clock; half period in edges
  logic [2:0] half;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       srcPrev_ff;
  logic       nxt_srcPrev;
  logic       div_ff;
  logic       nxt_div;
  logic       out_ff;
  logic       nxt_out;
  logic       run;

  always_comb begin
    case (freqSel)
      3'h0:    half = `RCS_DIV25;
      3'h1:    half = `RCS_DIV125;
      3'h2:    half = `RCS_DIV31;
      default: half = `RCS_DIV125;
    endcase
    run         = ctrl_ff[`RCS_ENABLE_BIT] && portOk && pathOk && freqOk
                  && !squelch && !squelchForce;
    nxt_srcPrev = srcClk;
    nxt_cnt     = cnt_ff;
    nxt_div     = div_ff;
    if (!run) begin
      nxt_cnt = 3'h0;
      nxt_div = 1'b0;
    end else if (srcClk && !srcPrev_ff) begin
      if (cnt_ff + 3'h1 >= half) begin
        nxt_cnt = 3'h0;
        nxt_div = !div_ff;
      end else begin
        nxt_cnt = cnt_ff + 3'h1;
      end
    end
    nxt_out = run && div_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff     <= 3'h0;
      srcPrev_ff <= 1'b0;
      div_ff     <= 1'b0;
      out_ff     <= 1'b0;
    end else begin
      cnt_ff     <= nxt_cnt;
      srcPrev_ff <= nxt_srcPrev;
      div_ff     <= nxt_div;
      out_ff     <= nxt_out;
    end
  end

  assign recovered_clock_out_two = out_ff;

endmodule : rcs_recovered_clock_output_select
`default_nettype wire
